/* File: hw/tcc_pkg.sv */
// shared constants and types of the capture/compare timer
package tcc_pkg;

   // widths
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W  = 16;

   // register offsets (byte addresses on the plain port)
   localparam logic [7:0] OFS_CONTROL = 8'h12;
   localparam logic [7:0] OFS_FLAGS   = 8'h13;
   localparam logic [7:0] OFS_CAP_HI  = 8'h14;
   localparam logic [7:0] OFS_CAP_LO  = 8'h15;
   localparam logic [7:0] OFS_CMP_HI  = 8'h16;
   localparam logic [7:0] OFS_CMP_LO  = 8'h17;
   localparam logic [7:0] OFS_CNT_HI  = 8'h18;
   localparam logic [7:0] OFS_CNT_LO  = 8'h19;
   localparam logic [7:0] OFS_ALT_HI  = 8'h1a;
   localparam logic [7:0] OFS_ALT_LO  = 8'h1b;

   // field positions in control and flag registers
   localparam int unsigned BIT_CAP   = 7;
   localparam int unsigned BIT_CMP   = 6;
   localparam int unsigned BIT_OVF   = 5;
   localparam int unsigned BIT_EDGE  = 1;
   localparam int unsigned BIT_LEVEL = 0;

   // reset values and counts
   localparam logic [15:0] CNT_RESET  = 16'hfffc;
   localparam logic [15:0] CNT_WRAP   = 16'hffff;
   localparam logic [15:0] CMP_RESET  = 16'hffff;
   localparam logic [1:0]  PRESC_LAST = 2'h3;
   localparam logic        PIN_RESET  = 1'b0;

   // one bit per timer event: capture, compare, overflow
   typedef struct packed {
      logic cap;
      logic cmp;
      logic ovf;
   } tcc_evt_type;

   localparam tcc_evt_type EVT_NONE = 3'h0;

endpackage

/* File: hw/tcc_timer.sv */
// capture/compare timer: counter, capture, compare, flags and registers
// Functional notes
// - counter advances once per four clocks
// - reading counter never disturbs counting
// - active capture edge copies counter value
// - edge select: 1 rising, 0 falling; kept
// - every fourth clock compare; match drives pin
// - level bit picks pin level; reset clears
// - three interrupt enables, cleared by reset
// - capture flag cleared: status read, capture low
// - compare flag cleared: status, compare low access
// - overflow flag on wrap, cleared via counter low
// - high read freezes low; writes ignored
// - alternate pair latches, never clears overflow
// - capture high read blocks capture until low
// - compare high write suspends matching until low
// - timer keeps running; interrupt wakes from wait
// - stop holds counter; reset forces fffc
// - stop clears prescaler and interrupt enables
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

module tcc_timer (
   // clock and resets
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   input  wire logic                        por,
   // low-power state from the core
   input  wire logic                        stop_mode,
   // register port
   input  wire logic [tcc_pkg::ADDR_W-1:0]  bus_addr,
   input  wire logic [tcc_pkg::DATA_W-1:0]  bus_wdata,
   input  wire logic                        bus_wr,
   input  wire logic                        bus_rd,
   output logic      [tcc_pkg::DATA_W-1:0]  bus_rdata,
   // pins
   input  wire logic                        capture_input_pin,
   output logic                             compare_output_pin,
   // interrupt request
   output logic                             irq
);

   logic [15:0]          counter_ff;
   logic [15:0]          nxt_counter;
   logic [1:0]           presc_ff;
   logic [2:0]           cap_sync_ff;
   logic [2:0]           cap_fill_ff;
   logic [15:0]          capture_ff;
   logic [15:0]          compare_ff;
   logic                 cmp_hold_ff;
   logic                 cap_block_ff;
   logic                 cnt_latched_ff;
   logic                 alt_latched_ff;
   logic [7:0]           cnt_lo_ff;
   logic [7:0]           alt_lo_ff;
   logic                 pin_ff;
   logic                 level_ff;
   logic                 edge_sel_ff;
   logic [7:0]           rdata_ff;
   tcc_pkg::tcc_evt_type enable_ff;
   tcc_pkg::tcc_evt_type flags_ff;
   tcc_pkg::tcc_evt_type armed_ff;
   tcc_pkg::tcc_evt_type nxt_flags;
   tcc_pkg::tcc_evt_type nxt_armed;

   // address decode
   wire rd_ctrl   = bus_rd && (bus_addr == tcc_pkg::OFS_CONTROL);
   wire rd_flags  = bus_rd && (bus_addr == tcc_pkg::OFS_FLAGS);
   wire rd_cap_hi = bus_rd && (bus_addr == tcc_pkg::OFS_CAP_HI);
   wire rd_cap_lo = bus_rd && (bus_addr == tcc_pkg::OFS_CAP_LO);
   wire rd_cmp_hi = bus_rd && (bus_addr == tcc_pkg::OFS_CMP_HI);
   wire rd_cmp_lo = bus_rd && (bus_addr == tcc_pkg::OFS_CMP_LO);
   wire rd_cnt_hi = bus_rd && (bus_addr == tcc_pkg::OFS_CNT_HI);
   wire rd_cnt_lo = bus_rd && (bus_addr == tcc_pkg::OFS_CNT_LO);
   wire rd_alt_hi = bus_rd && (bus_addr == tcc_pkg::OFS_ALT_HI);
   wire rd_alt_lo = bus_rd && (bus_addr == tcc_pkg::OFS_ALT_LO);
   wire wr_ctrl   = bus_wr && (bus_addr == tcc_pkg::OFS_CONTROL);
   wire wr_flags  = bus_wr && (bus_addr == tcc_pkg::OFS_FLAGS);
   wire wr_cmp_hi = bus_wr && (bus_addr == tcc_pkg::OFS_CMP_HI);
   wire wr_cmp_lo = bus_wr && (bus_addr == tcc_pkg::OFS_CMP_LO);

   // prescaler tick and counter events; stop suppresses tick, wrap and match
   wire tick      = !stop_mode && (presc_ff == tcc_pkg::PRESC_LAST);
   wire wrap      = tick && (counter_ff == tcc_pkg::CNT_WRAP);
   wire match     = tick && !cmp_hold_ff && (counter_ff == compare_ff);

   // capture edge from the second and third sync stages only
   wire cap_now   = cap_sync_ff[1];
   wire cap_prev  = cap_sync_ff[2];
   wire cap_edge  = edge_sel_ff ? (cap_now && !cap_prev)
                                : (!cap_now && cap_prev);
   wire capture   = cap_edge && !cap_block_ff && cap_fill_ff[2];

   // events and sequence clears; set beats clear in the same cycle
   wire tcc_pkg::tcc_evt_type evt = '{cap: capture, cmp: match, ovf: wrap};
   wire tcc_pkg::tcc_evt_type seq_clr = '{
      cap: armed_ff.cap && rd_cap_lo,
      cmp: armed_ff.cmp && (rd_cmp_lo || wr_cmp_lo),
      ovf: armed_ff.ovf && rd_cnt_lo
   };
   wire tcc_pkg::tcc_evt_type w1c_clr = wr_flags ?
      '{cap: bus_wdata[tcc_pkg::BIT_CAP], cmp: bus_wdata[tcc_pkg::BIT_CMP],
        ovf: bus_wdata[tcc_pkg::BIT_OVF]} : tcc_pkg::EVT_NONE;
   assign nxt_flags = evt | (flags_ff & ~(seq_clr | w1c_clr));

   // a status read arms each flag it sees set; arming ends with its clear
   assign nxt_armed = (armed_ff & ~seq_clr) | (rd_flags ? flags_ff : tcc_pkg::EVT_NONE);

   assign nxt_counter = counter_ff + 16'h0001;

   // register read multiplexer
   wire [7:0] cnt_lo_view = cnt_latched_ff ? cnt_lo_ff : counter_ff[7:0];
   wire [7:0] alt_lo_view = alt_latched_ff ? alt_lo_ff : counter_ff[7:0];
   wire [7:0] ctrl_view   = {enable_ff, 3'h0, edge_sel_ff, level_ff};
   wire [7:0] flags_view  = {flags_ff, 5'h00};
   wire [7:0] rd_mux =
      rd_ctrl   ? ctrl_view          :
      rd_flags  ? flags_view         :
      rd_cap_hi ? capture_ff[15:8]   :
      rd_cap_lo ? capture_ff[7:0]    :
      rd_cmp_hi ? compare_ff[15:8]   :
      rd_cmp_lo ? compare_ff[7:0]    :
      rd_cnt_hi ? counter_ff[15:8]   :
      rd_cnt_lo ? cnt_lo_view        :
      rd_alt_hi ? counter_ff[15:8]   :
      rd_alt_lo ? alt_lo_view        : 8'h00;

   // interrupt: level, so it also serves as the wake from wait
   assign irq = |(flags_ff & enable_ff);
   assign bus_rdata = rdata_ff;
   assign compare_output_pin = pin_ff;

   // read data register; unmapped addresses answer zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (bus_rd) begin
         rdata_ff <= rd_mux;
      end
   end

   // prescaler and free-running counter; reset leaves fffc
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         presc_ff   <= 2'h0;
         counter_ff <= tcc_pkg::CNT_RESET;
      end else if (stop_mode) begin
         presc_ff   <= 2'h0;
      end else begin
         presc_ff   <= presc_ff + 2'h1;
         if (tick) begin
            counter_ff <= nxt_counter;
         end
      end
   end

   // capture pin synchroniser plus one stage for edge detection
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cap_sync_ff <= 3'h0;
      end else begin
         cap_sync_ff <= {cap_sync_ff[1:0], capture_input_pin};
      end
   end

   // sync stages hold no real pin sample after rst; a high pin would fake an edge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cap_fill_ff <= 3'h0;
      end else begin
         cap_fill_ff <= {cap_fill_ff[1:0], 1'b1};
      end
   end

   // capture value and high-byte blocking
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         capture_ff   <= 16'h0000;
         cap_block_ff <= 1'b0;
      end else begin
         if (capture) begin
            capture_ff <= counter_ff;
         end
         if (rd_cap_hi) begin
            cap_block_ff <= 1'b1;
         end else if (rd_cap_lo) begin
            cap_block_ff <= 1'b0;
         end
      end
   end

   // counter read latches; writes to these offsets are dropped
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_latched_ff <= 1'b0;
         alt_latched_ff <= 1'b0;
         cnt_lo_ff      <= 8'h00;
         alt_lo_ff      <= 8'h00;
      end else begin
         if (rd_cnt_hi) begin
            cnt_latched_ff <= 1'b1;
            cnt_lo_ff      <= counter_ff[7:0];
         end else if (rd_cnt_lo) begin
            cnt_latched_ff <= 1'b0;
         end
         if (rd_alt_hi) begin
            alt_latched_ff <= 1'b1;
            alt_lo_ff      <= counter_ff[7:0];
         end else if (rd_alt_lo) begin
            alt_latched_ff <= 1'b0;
         end
      end
   end

   // compare value: high write holds matching until low write
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         compare_ff  <= tcc_pkg::CMP_RESET;
         cmp_hold_ff <= 1'b0;
      end else begin
         if (wr_cmp_hi) begin
            compare_ff[15:8] <= bus_wdata;
            cmp_hold_ff      <= 1'b1;
         end
         if (wr_cmp_lo) begin
            compare_ff[7:0] <= bus_wdata;
            cmp_hold_ff     <= 1'b0;
         end
      end
   end

   // compare pin follows the level bit on each match
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_ff <= tcc_pkg::PIN_RESET;
      end else if (match) begin
         pin_ff <= level_ff;
      end
   end

   // enables and level bit cleared by reset; stop strips the enables
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enable_ff <= tcc_pkg::EVT_NONE;
         level_ff  <= 1'b0;
      end else if (stop_mode) begin
         enable_ff <= tcc_pkg::EVT_NONE;
      end else if (wr_ctrl) begin
         enable_ff <= bus_wdata[tcc_pkg::BIT_CAP:tcc_pkg::BIT_OVF];
         level_ff  <= bus_wdata[tcc_pkg::BIT_LEVEL];
      end
   end

   // flags and edge select survive rst; only power-on clears them
   always_ff @(posedge core_clk or posedge por) begin
      if (por) begin
         flags_ff    <= tcc_pkg::EVT_NONE;
         armed_ff    <= tcc_pkg::EVT_NONE;
         edge_sel_ff <= 1'b0;
      end else begin
         flags_ff <= nxt_flags;
         armed_ff <= nxt_armed;
         if (wr_ctrl) begin
            edge_sel_ff <= bus_wdata[tcc_pkg::BIT_EDGE];
         end
      end
   end

   // checks
   count_step_a: assert property (@(posedge core_clk) disable iff (rst)
      tick |=> counter_ff == $past(nxt_counter))
      else $error("counter did not step on tick");

   count_still_a: assert property (@(posedge core_clk) disable iff (rst)
      (!tick && !$past(rst)) |=> $stable(counter_ff))
      else $error("counter moved without tick");

   tick_spacing_a: assert property (@(posedge core_clk) disable iff (rst)
      (tick && !stop_mode) |=> !tick [*3])
      else $error("prescaler tick closer than four clocks");

   capture_copy_a: assert property (@(posedge core_clk) disable iff (rst)
      capture |=> capture_ff == $past(counter_ff) && flags_ff.cap)
      else $error("capture did not copy counter");

   capture_block_a: assert property (@(posedge core_clk) disable iff (rst)
      (cap_block_ff && !rd_cap_lo) |=> $stable(capture_ff))
      else $error("capture changed while blocked");

   compare_pin_a: assert property (@(posedge core_clk) disable iff (rst)
      match |=> compare_output_pin == $past(level_ff) && flags_ff.cmp)
      else $error("compare pin or flag wrong after match");

   compare_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (cmp_hold_ff && !flags_ff.cmp) |=> !flags_ff.cmp)
      else $error("compare flag set while compare suspended");

   overflow_flag_a: assert property (@(posedge core_clk) disable iff (rst)
      wrap |=> flags_ff.ovf && counter_ff == 16'h0000)
      else $error("overflow flag missing after wrap");

   alt_keeps_ovf_a: assert property (@(posedge core_clk) disable iff (rst)
      (flags_ff.ovf && rd_alt_lo && !wr_flags) |=> flags_ff.ovf)
      else $error("alternate read cleared overflow");

   latch_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (rd_cnt_hi ##1 (!rd_cnt_lo && !rd_cnt_hi) [*2]) |-> $stable(cnt_lo_ff))
      else $error("latched low byte changed");

   stop_mask_a: assert property (@(posedge core_clk) disable iff (rst)
      stop_mode |=> enable_ff == tcc_pkg::EVT_NONE && presc_ff == 2'h0)
      else $error("stop left enables or prescaler");

   irq_level_a: assert property (@(posedge core_clk) disable iff (rst)
      irq == (flags_ff.cap && enable_ff.cap || flags_ff.cmp && enable_ff.cmp
              || flags_ff.ovf && enable_ff.ovf))
      else $error("interrupt disagrees with flags");

   cap_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      (rd_flags && flags_ff.cap ##1 (!rd_cap_lo && !capture) [*3] ##1 rd_cap_lo && !capture)
      |=> !flags_ff.cap)
      else $error("capture flag not cleared by sequence");

   reset_ctrl_a: assert property (@(posedge core_clk)
      $fell(rst) |-> enable_ff == tcc_pkg::EVT_NONE && !level_ff)
      else $error("enables or level bit survived reset");

   reset_count_a: assert property (@(posedge core_clk)
      $fell(rst) |-> counter_ff == tcc_pkg::CNT_RESET && presc_ff == 2'h0)
      else $error("counter or prescaler wrong after reset");

   capture_settle_a: assert property (@(posedge core_clk)
      $fell(rst) |-> !capture [*3])
      else $error("capture right after reset release");

   alt_latch_a: assert property (@(posedge core_clk) disable iff (rst)
      rd_alt_hi |=> alt_lo_ff == $past(counter_ff[7:0]))
      else $error("alternate low byte not latched");

   flags_read_a: assert property (@(posedge core_clk) disable iff (rst)
      rd_flags |=> bus_rdata == {$past(flags_ff), 5'h00})
      else $error("status read data wrong");

endmodule

/* File: test/tcc_pin_model.sv */
// stand-in for the outside world driving the capture pin
`timescale 1ns/1ps

module tcc_pin_model (
   // clock
   input  wire logic core_clk,
   // requested level and the pin itself
   input  wire logic want_level,
   output logic      capture_input_pin
);
   int unsigned lag;

   // follow the request after a random lag, so edges land prompt or slow
   initial begin
      capture_input_pin = 1'b0;
      forever begin
         @(posedge core_clk);
         if (want_level !== capture_input_pin) begin
            lag = $urandom_range(3, 0);
            repeat (lag) @(posedge core_clk);
            capture_input_pin <= want_level;
         end
      end
   end
endmodule

/* File: test/capture_compare_timer16_test.sv */
// self-checking bench of the capture/compare timer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end

module capture_compare_timer16_test;
   logic        core_clk, rst, por, stop_mode, bus_wr, bus_rd, want_level;
   logic [7:0]  bus_addr, bus_wdata, bus_rdata, rd_val;
   logic        capture_input_pin, compare_output_pin, irq;
   logic [15:0] v1, v2, cap, tgt;
   int          miscompares = 0;
   int          comparisons = 0;

   tcc_timer DUT (
      .core_clk(core_clk), .rst(rst), .por(por), .stop_mode(stop_mode),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .capture_input_pin(capture_input_pin),
      .compare_output_pin(compare_output_pin), .irq(irq));

   tcc_pin_model pins (.core_clk(core_clk), .want_level(want_level),
      .capture_input_pin(capture_input_pin));

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge core_clk);
      bus_wr    <= 1'b0;
   endtask

   // one-cycle read strobe; data only valid in the following cycle
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge core_clk);
      bus_rd   <= 1'b0;
      #1;
      rd_val = bus_rdata;
   endtask

   // high byte first so the low byte comes from the same instant
   task automatic rd16(input logic [7:0] hi, output logic [15:0] v);
      rd(hi);
      v[15:8] = rd_val;
      rd(hi + 8'h01);
      v[7:0] = rd_val;
   endtask

   // expected count after a span of clocks
   function automatic logic [15:0] after_ticks(logic [15:0] v, int unsigned cyc);
      return v + 16'(cyc / 4);
   endfunction

   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // 100 mhz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // watchdog well beyond the expected run length
   initial begin
      repeat (50000) @(posedge core_clk);
      miscompares++;
      end_of_test();
   end

   initial begin
      rst        = 1'b1;
      por        = 1'b1;
      stop_mode  = 1'b0;
      bus_wr     = 1'b0;
      bus_rd     = 1'b0;
      bus_addr   = 8'h00;
      bus_wdata  = 8'h00;
      want_level = 1'b0;
      void'($urandom(32'hfcc5));
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      por <= 1'b0;
      // counter starts near the top, so it wraps soon after reset
      repeat (30) @(posedge core_clk);
      rd(tcc_pkg::OFS_CONTROL);
      `CHK("control", 8'h00, rd_val)
      rd(tcc_pkg::OFS_FLAGS);
      `CHK("overflow set", 1'b1, rd_val[tcc_pkg::BIT_OVF])
      rd(tcc_pkg::OFS_ALT_LO);
      rd(tcc_pkg::OFS_FLAGS);
      `CHK("alt keeps flag", 1'b1, rd_val[tcc_pkg::BIT_OVF])
      wr(tcc_pkg::OFS_CONTROL, 8'h20);
      #1;
      `CHK("irq overflow", 1'b1, irq)
      rd(tcc_pkg::OFS_CNT_LO);
      rd(tcc_pkg::OFS_FLAGS);
      `CHK("overflow cleared", 1'b0, rd_val[tcc_pkg::BIT_OVF])
      `CHK("irq idle", 1'b0, irq)
      wr(tcc_pkg::OFS_CAP_LO, 8'h5a);
      rd(tcc_pkg::OFS_CAP_LO);
      `CHK("capture write ignored", 8'h00, rd_val)
      // reads in between must not disturb the count
      rd16(tcc_pkg::OFS_CNT_HI, v1);
      repeat (400) @(posedge core_clk);
      rd16(tcc_pkg::OFS_ALT_HI, v2);
      `CHK("count rate", after_ticks(v1, 404), v2)
      // stop freezes the count and drops the enables
      wr(tcc_pkg::OFS_CONTROL, 8'he0);
      stop_mode <= 1'b1;
      rd16(tcc_pkg::OFS_CNT_HI, v1);
      repeat (40) @(posedge core_clk);
      rd16(tcc_pkg::OFS_CNT_HI, v2);
      `CHK("stop holds", v1, v2)
      rd(tcc_pkg::OFS_CONTROL);
      `CHK("stop enables", 8'h00, rd_val & 8'he0)
      stop_mode <= 1'b0;
      // rising edge, then falling edge
      for (int e = 1; e >= 0; e--) begin
         wr(tcc_pkg::OFS_CONTROL, e ? 8'h82 : 8'h80);
         rd16(tcc_pkg::OFS_CNT_HI, v1);
         want_level <= 1'(e);
         repeat (12) @(posedge core_clk);
         rd16(tcc_pkg::OFS_CNT_HI, v2);
         rd(tcc_pkg::OFS_FLAGS);
         `CHK("capture flag", 1'b1, rd_val[tcc_pkg::BIT_CAP])
         `CHK("capture irq", 1'b1, irq)
         rd16(tcc_pkg::OFS_CAP_HI, cap);
         `CHK("capture in span", 1'b1, cap >= v1 && cap <= v2)
         rd(tcc_pkg::OFS_FLAGS);
         `CHK("capture cleared", 1'b0, rd_val[tcc_pkg::BIT_CAP])
      end
      // a falling edge while the high byte is held must not capture
      rd(tcc_pkg::OFS_CAP_HI);
      want_level <= 1'b1;
      repeat (12) @(posedge core_clk);
      want_level <= 1'b0;
      repeat (12) @(posedge core_clk);
      rd(tcc_pkg::OFS_CAP_LO);
      `CHK("capture blocked", cap[7:0], rd_val)
      // drive high, then low, at random distances ahead
      for (int l = 1; l >= 0; l--) begin
         wr(tcc_pkg::OFS_CONTROL, 8'h40 | 8'(l));
         rd16(tcc_pkg::OFS_CNT_HI, v1);
         tgt = v1 + 16'(12 + $urandom_range(20, 0));
         wr(tcc_pkg::OFS_CMP_HI, tgt[15:8]);
         rd(tcc_pkg::OFS_FLAGS);
         wr(tcc_pkg::OFS_CMP_LO, tgt[7:0]);
         for (int k = 0; k < 200 && compare_output_pin !== 1'(l); k++) begin
            @(posedge core_clk);
            #1;
         end
         rd16(tcc_pkg::OFS_CNT_HI, v2);
         `CHK("compare pin", 1'(l), compare_output_pin)
         `CHK("compare time", 1'b1, (v2 - tgt) inside {16'h0001, 16'h0002})
         rd(tcc_pkg::OFS_FLAGS);
         `CHK("compare flag", 1'b1, rd_val[tcc_pkg::BIT_CMP])
         `CHK("compare irq", 1'b1, irq)
         rd(tcc_pkg::OFS_CMP_LO);
         `CHK("compare low", tgt[7:0], rd_val)
         rd(tcc_pkg::OFS_FLAGS);
         `CHK("compare cleared", 1'b0, rd_val[tcc_pkg::BIT_CMP])
      end
      // a lone high write leaves matching off past the target
      wr(tcc_pkg::OFS_CONTROL, 8'h01);
      rd16(tcc_pkg::OFS_CNT_HI, v1);
      tgt = v1 + 16'h000c;
      wr(tcc_pkg::OFS_CMP_HI, tgt[15:8]);
      wr(tcc_pkg::OFS_CMP_LO, tgt[7:0]);
      wr(tcc_pkg::OFS_CMP_HI, tgt[15:8]);
      repeat (80) @(posedge core_clk);
      `CHK("compare suspended", 1'b0, compare_output_pin)
      // rst alone out of stop: edge select and flags survive, count restarts
      wr(tcc_pkg::OFS_CONTROL, 8'he2);
      want_level <= 1'b1;
      repeat (12) @(posedge core_clk);
      stop_mode <= 1'b1;
      repeat (8) @(posedge core_clk);
      `CHK("stop drops irq", 1'b0, irq)
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst       <= 1'b0;
      stop_mode <= 1'b0;
      rd16(tcc_pkg::OFS_CNT_HI, v1);
      `CHK("count after rst", tcc_pkg::CNT_RESET, v1)
      rd(tcc_pkg::OFS_CONTROL);
      `CHK("control after rst", 8'h02, rd_val)
      rd(tcc_pkg::OFS_FLAGS);
      `CHK("flags after rst", 8'h80, rd_val)
      `CHK("irq after rst", 1'b0, irq)
      rd16(tcc_pkg::OFS_CAP_HI, cap);
      `CHK("no capture at rst", 16'h0000, cap)
      end_of_test();
   end
endmodule
